// File: rtl/thd_pkg.sv
// Purpose: Shared constants for the TDM highway data pin block
// Assumes: Registers are 8 bits wide, one per aligned 32-bit APB word
// Notes:   Register index times four gives the byte address
package thd_pkg;

  localparam int unsigned REG_W     = 8;
  localparam int unsigned CNT_W     = 10;
  localparam int unsigned BYTE_BITS = 8;

  // Register indices
  localparam logic [3:0] IDX_CFG    = 4'h0;
  localparam logic [3:0] IDX_RXCTL  = 4'h5;
  localparam logic [3:0] IDX_TXSLOT = 4'h7;
  localparam logic [3:0] IDX_RXSLOT = 4'h8;
  localparam logic [3:0] IDX_OFFS   = 4'h9;
  localparam logic [3:0] IDX_TXCFG  = 4'hA;
  localparam logic [3:0] IDX_RXCFG  = 4'hB;
  localparam logic [3:0] IDX_TXDAT  = 4'hC;
  localparam logic [3:0] IDX_RXDAT  = 4'hD;
  localparam logic [3:0] IDX_STAT   = 4'hF;

  // Field positions
  localparam int unsigned B_HWY_EN    = 7;
  localparam int unsigned B_PIN17_SEL = 7;
  localparam int unsigned B_PIN21_SEL = 6;
  localparam int unsigned B_PRI_EN    = 7;
  localparam int unsigned B_SEC_EN    = 6;
  localparam int unsigned B_RX_SEL    = 7;
  localparam int unsigned B_TXCLK_INV = 4;
  localparam int unsigned B_RX_EDGE   = 0;
  localparam int unsigned B_INV       = 7;
  localparam int unsigned B_ORDER     = 6;
  localparam int unsigned B_RX_FULL   = 0;
  localparam int unsigned B_TX_TAKEN  = 1;
  localparam int unsigned SLOT_MSB    = 5;
  localparam int unsigned TXOFF_MSB   = 7;
  localparam int unsigned TXOFF_LSB   = 5;
  localparam int unsigned RXOFF_MSB   = 3;
  localparam int unsigned RXOFF_LSB   = 1;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OFFS = 8'h01;

  // Synchroniser lanes
  localparam int unsigned SYNC_W = 4;
  localparam int unsigned S_TXCLK = 0;
  localparam int unsigned S_PIN21 = 1;
  localparam int unsigned S_RXD   = 2;
  localparam int unsigned S_FRM   = 3;

endpackage

// File: rtl/thd_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module thd_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

// File: rtl/thd_highway_pins.sv
// Purpose: TDM highway transmit/receive pin logic with APB registers
// Assumes: pclk at 40 MHz, bit clocks below half of it
// Notes:   Pin 21 doubles as second receive data input
// Functional notes
// [RULE_01] Pin-select 0 second data, 1 strobe
// [RULE_02] Second output drives only when enabled
// [RULE_03] Launch on falling edge, invert selects rising
// [RULE_04] Transmit invert flips active output data
// [RULE_05] Transmit bit order bit0 or bit7 first
// [RULE_06] Transmit placed at programmed slot and offset
// [RULE_07] Strobe low exactly during primary valid bits
// [RULE_08] Strobe mode overrides second output enable
// [RULE_09] Software sets primary enable for external driver
// [RULE_10] Primary output drives only when enabled
// [RULE_11] Both enabled outputs carry identical data
// [RULE_12] Bit clocks stay below half master clock
// [RULE_13] Pin-21 function uses transmit clock for receive
// [RULE_14] Input select 0 takes primary receive data
// [RULE_15] Receive invert flips incoming data
// [RULE_16] Receive edge chosen by edge bit
// [RULE_17] Receive slot, assembled in chosen bit order
// [RULE_18] Receive edge resets to rising
// [RULE_19] Pin 21 becomes second receive input
// [RULE_20] Slots count from frame sync, gated
// [RULE_21] Outputs released outside own slot
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module thd_highway_pins (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_bit_clock,
  input  wire logic        rx_bit_clock,
  input  wire logic        rx_data_primary,
  input  wire logic        frame_sync_pulse,
  output logic             tx_data_primary,
  output logic             primary_tx_oe,
  output logic             shared_tx_pin,
  output logic             shared_tx_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] cfg_q;
  logic [7:0] rxctl_q;
  logic [7:0] txslot_q;
  logic [7:0] rxslot_q;
  logic [7:0] offs_q;
  logic [7:0] txcfg_q;
  logic [7:0] rxcfg_q;
  logic [7:0] txdat_q;
  logic [7:0] rxdat_q;
  logic       rx_full_q;
  logic       tx_taken_q;

  wire highway_enable             = cfg_q[thd_pkg::B_HWY_EN];
  wire shared_tx_pin_function_sel = rxctl_q[thd_pkg::B_PIN17_SEL];
  wire rx_pin_function_sel        = rxctl_q[thd_pkg::B_PIN21_SEL];
  wire primary_tx_out_en          = txslot_q[thd_pkg::B_PRI_EN];
  wire second_tx_out_en           = txslot_q[thd_pkg::B_SEC_EN];
  wire rx_input_select            = rxslot_q[thd_pkg::B_RX_SEL];
  wire tx_clock_edge_invert       = offs_q[thd_pkg::B_TXCLK_INV];
  wire rx_clock_edge_sel          = offs_q[thd_pkg::B_RX_EDGE];
  wire tx_data_invert             = txcfg_q[thd_pkg::B_INV];
  wire tx_bit_order               = txcfg_q[thd_pkg::B_ORDER];
  wire rx_data_invert             = rxcfg_q[thd_pkg::B_INV];
  wire rx_bit_order               = rxcfg_q[thd_pkg::B_ORDER];

  wire [5:0] tx_slot = txslot_q[thd_pkg::SLOT_MSB:0];
  wire [5:0] rx_slot = rxslot_q[thd_pkg::SLOT_MSB:0];
  wire [2:0] tx_off  = offs_q[thd_pkg::TXOFF_MSB:thd_pkg::TXOFF_LSB];
  wire [2:0] rx_off  = offs_q[thd_pkg::RXOFF_MSB:thd_pkg::RXOFF_LSB];

  function automatic logic [2:0] bit_pos(input logic [2:0] k, input logic msb_first);
    bit_pos = msb_first ? (3'h7 - k) : k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  logic [7:0] rd_byte;
  logic       hit;
  wire  [3:0] idx     = paddr[5:2];
  wire        word_ok = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
  wire        setup   = psel && !penable;
  wire        wr_en   = psel && penable && pready && pwrite && hit;

  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    if (!word_ok) begin
      hit = 1'b0;
    end else if (idx == thd_pkg::IDX_CFG) begin
      rd_byte = cfg_q;
    end else if (idx == thd_pkg::IDX_RXCTL) begin
      rd_byte = rxctl_q;
    end else if (idx == thd_pkg::IDX_TXSLOT) begin
      rd_byte = txslot_q;
    end else if (idx == thd_pkg::IDX_RXSLOT) begin
      rd_byte = rxslot_q;
    end else if (idx == thd_pkg::IDX_OFFS) begin
      rd_byte = offs_q;
    end else if (idx == thd_pkg::IDX_TXCFG) begin
      rd_byte = txcfg_q;
    end else if (idx == thd_pkg::IDX_RXCFG) begin
      rd_byte = rxcfg_q;
    end else if (idx == thd_pkg::IDX_TXDAT) begin
      rd_byte = txdat_q;
    end else if (idx == thd_pkg::IDX_RXDAT) begin
      rd_byte = rxdat_q;
    end else if (idx == thd_pkg::IDX_STAT) begin
      rd_byte = {6'h00, tx_taken_q, rx_full_q};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= (setup && !pwrite && hit) ? {24'h0, rd_byte} : 32'h0;
    end
  end

  wire [7:0] wbyte = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q    <= thd_pkg::RST_ZERO;
      rxctl_q  <= thd_pkg::RST_ZERO;
      txslot_q <= thd_pkg::RST_ZERO;
      rxslot_q <= thd_pkg::RST_ZERO;
      offs_q   <= thd_pkg::RST_OFFS; // [RULE_03] [RULE_18]
      txcfg_q  <= thd_pkg::RST_ZERO;
      rxcfg_q  <= thd_pkg::RST_ZERO;
      txdat_q  <= thd_pkg::RST_ZERO;
    end else if (wr_en) begin
      if (idx == thd_pkg::IDX_CFG) cfg_q <= wbyte;
      if (idx == thd_pkg::IDX_RXCTL) rxctl_q <= wbyte;
      if (idx == thd_pkg::IDX_TXSLOT) txslot_q <= wbyte;
      if (idx == thd_pkg::IDX_RXSLOT) rxslot_q <= wbyte;
      if (idx == thd_pkg::IDX_OFFS) offs_q <= wbyte;
      if (idx == thd_pkg::IDX_TXCFG) txcfg_q <= wbyte;
      if (idx == thd_pkg::IDX_RXCFG) rxcfg_q <= wbyte;
      if (idx == thd_pkg::IDX_TXDAT) txdat_q <= wbyte;
    end
  end

  wire stat_wr = wr_en && (idx == thd_pkg::IDX_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [thd_pkg::SYNC_W-1:0] sync_q;
  logic [thd_pkg::SYNC_W-1:0] prev_q;

  thd_sync #(
    .W (thd_pkg::SYNC_W)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({frame_sync_pulse, rx_data_primary, rx_bit_clock, tx_bit_clock}),
    .q     (sync_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= sync_q;
    end
  end

  // Edge finding holds while bit clocks stay below half of pclk [RULE_12]
  wire txclk_rise = sync_q[thd_pkg::S_TXCLK] && !prev_q[thd_pkg::S_TXCLK];
  wire txclk_fall = !sync_q[thd_pkg::S_TXCLK] && prev_q[thd_pkg::S_TXCLK];
  wire tx_launch  = tx_clock_edge_invert ? txclk_rise : txclk_fall; // [RULE_03]

  wire rxclk_now  = rx_pin_function_sel ? sync_q[thd_pkg::S_TXCLK]
                                        : sync_q[thd_pkg::S_PIN21]; // [RULE_13]
  wire rxclk_old  = rx_pin_function_sel ? prev_q[thd_pkg::S_TXCLK]
                                        : prev_q[thd_pkg::S_PIN21]; // [RULE_13]
  wire rx_sample  = rx_clock_edge_sel ? (rxclk_now && !rxclk_old)
                                      : (!rxclk_now && rxclk_old); // [RULE_16] [RULE_18]

  wire frm_rise = highway_enable && sync_q[thd_pkg::S_FRM] && !prev_q[thd_pkg::S_FRM]; // [RULE_20]

  ////////////////////////////////////////////////////////////////////////////
  // Transmit slot timing
  localparam logic [thd_pkg::CNT_W-1:0] CNT_MAX = '1;
  localparam logic [thd_pkg::CNT_W-1:0] CNT_BYTE = thd_pkg::CNT_W'(thd_pkg::BYTE_BITS);

  logic [thd_pkg::CNT_W-1:0] tx_cnt_q;
  logic [7:0]                tx_hold_q;
  logic                      tx_active_q;
  logic                      tx_bit_q;

  wire [thd_pkg::CNT_W-1:0] tx_start = (thd_pkg::CNT_W'(tx_slot) << 3)
                                       + thd_pkg::CNT_W'(tx_off); // [RULE_06]
  wire [thd_pkg::CNT_W-1:0] tx_rel   = tx_cnt_q - tx_start;
  wire       tx_in_slot = (tx_cnt_q >= tx_start) && (tx_rel < CNT_BYTE); // [RULE_06]
  wire       tx_first   = tx_in_slot && (tx_rel == '0);
  wire [7:0] tx_byte    = tx_first ? txdat_q : tx_hold_q;
  wire       tx_raw     = tx_byte[bit_pos(tx_rel[2:0], tx_bit_order)]; // [RULE_05]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_q <= CNT_MAX;
    end else if (frm_rise) begin
      tx_cnt_q <= '0; // [RULE_20]
    end else if (!highway_enable) begin
      tx_cnt_q <= CNT_MAX;
    end else if (tx_launch && tx_cnt_q != CNT_MAX) begin
      tx_cnt_q <= tx_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_active_q <= 1'b0;
      tx_bit_q    <= 1'b1;
      tx_hold_q   <= thd_pkg::RST_ZERO;
    end else if (tx_launch) begin
      tx_active_q <= tx_in_slot && highway_enable; // [RULE_21]
      if (tx_in_slot) tx_bit_q <= tx_raw; // [RULE_03]
      if (tx_first) tx_hold_q <= txdat_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit pins
  wire pri_oe_d  = tx_active_q && primary_tx_out_en && highway_enable; // [RULE_10] [RULE_21]
  wire sec_oe_d  = tx_active_q && second_tx_out_en && highway_enable
                   && !shared_tx_pin_function_sel; // [RULE_02] [RULE_08]
  wire tx_line   = tx_bit_q ^ tx_data_invert; // [RULE_04] [RULE_11]
  wire strobe_n  = !pri_oe_d; // [RULE_07]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_primary  <= 1'b1;
      primary_tx_oe    <= 1'b0;
      shared_tx_pin    <= 1'b1;
      shared_tx_pin_oe <= 1'b0;
    end else begin
      tx_data_primary  <= tx_line;
      primary_tx_oe    <= pri_oe_d;
      shared_tx_pin    <= shared_tx_pin_function_sel ? strobe_n : tx_line; // [RULE_01]
      shared_tx_pin_oe <= shared_tx_pin_function_sel || sec_oe_d; // [RULE_01] [RULE_08]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive slot timing and assembly
  logic [thd_pkg::CNT_W-1:0] rx_cnt_q;
  logic [7:0]                rx_shift_q;
  logic [7:0]                rx_asm;

  wire use_second = rx_input_select && rx_pin_function_sel; // [RULE_14] [RULE_19]
  wire rx_pin_bit = use_second ? sync_q[thd_pkg::S_PIN21] : sync_q[thd_pkg::S_RXD];
  wire rx_bit_in  = rx_pin_bit ^ rx_data_invert; // [RULE_15]

  wire [thd_pkg::CNT_W-1:0] rx_start = (thd_pkg::CNT_W'(rx_slot) << 3)
                                       + thd_pkg::CNT_W'(rx_off);
  wire [thd_pkg::CNT_W-1:0] rx_rel   = rx_cnt_q - rx_start;
  wire       rx_in_slot = (rx_cnt_q >= rx_start) && (rx_rel < CNT_BYTE); // [RULE_17]
  wire [2:0] rx_k       = rx_rel[2:0];
  wire       rx_done    = rx_sample && rx_in_slot && (rx_k == 3'h7);

  always_comb begin
    rx_asm = rx_shift_q;
    rx_asm[bit_pos(rx_k, rx_bit_order)] = rx_bit_in; // [RULE_17]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_q <= CNT_MAX;
    end else if (frm_rise) begin
      rx_cnt_q <= '0; // [RULE_20]
    end else if (!highway_enable) begin
      rx_cnt_q <= CNT_MAX;
    end else if (rx_sample && rx_cnt_q != CNT_MAX) begin
      rx_cnt_q <= rx_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift_q <= thd_pkg::RST_ZERO;
      rxdat_q    <= thd_pkg::RST_ZERO;
    end else if (rx_sample && rx_in_slot) begin
      rx_shift_q <= rx_asm; // [RULE_16]
      if (rx_k == 3'h7) rxdat_q <= rx_asm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, set wins over write-one-to-clear
  wire tx_took = tx_launch && tx_first;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_q  <= 1'b0;
      tx_taken_q <= 1'b0;
    end else begin
      if (rx_done) rx_full_q <= 1'b1;
      else if (stat_wr && wbyte[thd_pkg::B_RX_FULL]) rx_full_q <= 1'b0;
      if (tx_took) tx_taken_q <= 1'b1;
      else if (stat_wr && wbyte[thd_pkg::B_TX_TAKEN]) tx_taken_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_STROBE_DRIVEN: assert property ( // [RULE_01]
    $past(shared_tx_pin_function_sel) |-> shared_tx_pin_oe)
    else $error("shared pin not driven in strobe mode");

  AST_SECOND_GATED: assert property ( // [RULE_02]
    shared_tx_pin_oe && !$past(shared_tx_pin_function_sel)
      |-> $past(second_tx_out_en) && $past(tx_active_q))
    else $error("second output driven while disabled");

  AST_LAUNCH_EDGE: assert property ( // [RULE_03]
    $changed(tx_bit_q) |-> $past(tx_launch))
    else $error("transmit bit changed off launch edge");

  AST_TX_INVERT: assert property ( // [RULE_04]
    primary_tx_oe |-> tx_data_primary == ($past(tx_bit_q) ^ $past(tx_data_invert)))
    else $error("primary data not inverted as programmed");

  AST_STROBE_LEVEL: assert property ( // [RULE_07]
    $past(shared_tx_pin_function_sel) |-> shared_tx_pin == !primary_tx_oe)
    else $error("strobe does not mirror primary slot");

  AST_STROBE_NO_DATA: assert property ( // [RULE_08]
    $past(shared_tx_pin_function_sel) && !$past(tx_active_q) |-> shared_tx_pin)
    else $error("data leaked onto shared pin in strobe mode");

  AST_PRIMARY_GATED: assert property ( // [RULE_10]
    primary_tx_oe |-> $past(primary_tx_out_en) && $past(highway_enable))
    else $error("primary output driven while disabled");

  AST_DUAL_SAME: assert property ( // [RULE_11]
    primary_tx_oe && shared_tx_pin_oe && !$past(shared_tx_pin_function_sel)
      |-> tx_data_primary == shared_tx_pin)
    else $error("dual outputs differ");

  AST_RX_CAPTURE: assert property ( // [RULE_17]
    $rose(rx_full_q) |-> $past(rx_done) && rxdat_q == $past(rx_asm))
    else $error("receive byte stored off slot end");

  AST_RX_EDGE: assert property ( // [RULE_16]
    $changed(rx_shift_q) |-> $past(rx_sample) && $past(rx_in_slot))
    else $error("receive bit taken off sample edge");

  AST_HWY_IDLE: assert property ( // [RULE_20]
    !highway_enable |=> !primary_tx_oe)
    else $error("output driven with highway disabled");

  AST_OUT_OF_SLOT: assert property ( // [RULE_21]
    !tx_active_q |=> !primary_tx_oe)
    else $error("primary driven outside its slot");

  CVR_DUAL_TX: cover property (primary_tx_oe && shared_tx_pin_oe && !shared_tx_pin_function_sel);
  CVR_STROBE_LOW: cover property (shared_tx_pin_function_sel && !shared_tx_pin);
  CVR_RX_BYTE: cover property (rx_done);

endmodule

// File: verification/thd_highway_model.sv
// Purpose: Far side of the TDM highway: bit clocks, frame sync, receive data
// Assumes: A frame is started right after a pclk edge; bit period 200 ns
// Notes:   Transmit pins are captured just before each following launch edge
`timescale 1ns/1ps
module thd_highway_model #(
  parameter int NB = 32
) (
  output logic      tx_bit_clock,
  output logic      rx_bit_clock,
  output logic      rx_data_primary,
  output logic      frame_sync_pulse,
  input  wire logic tx_data_primary,
  input  wire logic primary_tx_oe,
  input  wire logic shared_tx_pin,
  input  wire logic shared_tx_pin_oe
);
  logic [3:0]    lane_f [NB];
  logic [3:0]    lane_r [NB];
  logic [NB-1:0] pq;
  logic          p21;
  logic          busy;
  logic          bclk;
  logic          tog;
  int            idx;
  wire  [3:0]    pins;
  wire           da;

  ////////////////////////////////////////////////////////////////////////////////
  // Line drivers; released lines carry a changing pattern
  assign pins = {shared_tx_pin_oe, shared_tx_pin, primary_tx_oe, tx_data_primary};
  assign da = pq[idx % NB];
  assign tx_bit_clock = bclk;
  assign rx_data_primary = busy ? da : tog;
  assign rx_bit_clock = p21 ? (busy ? ~da : tog) : bclk;

  initial begin
    bclk = 1'b1;
    tog = 1'b0;
    busy = 1'b0;
    p21 = 1'b0;
    idx = 0;
    pq = '0;
    frame_sync_pulse = 1'b0;
  end

  always #30 tog = ~tog;

  ////////////////////////////////////////////////////////////////////////////////
  // One frame: sync pulse, then NB bit periods plus one; clock idles high
  task automatic run_frame(input logic [NB-1:0] pat, input logic pin21);
    int i;
    pq = pat;
    p21 = pin21;
    idx = 0;
    busy = 1'b1;
    frame_sync_pulse = 1'b1;
    #100 frame_sync_pulse = 1'b0;
    #100;
    for (i = 0; i <= NB; i++) begin
      bclk = 1'b0;
      #90;
      if (i > 0) lane_r[i-1] = pins;
      #10 bclk = 1'b1;
      #50 idx = i + 1;
      #40;
      if (i < NB) lane_f[i] = pins;
      #10;
    end
    busy = 1'b0;
  endtask
endmodule

// File: verification/testbench.sv
// Purpose: Self-checking bench for the TDM highway pin block
// Assumes: APB answers in one access cycle; model bit period 200 ns
// Notes:   Expected pin values worked out per bit position of the frame
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0]  TXD = 8'h4D;
  localparam logic [31:0] PAT = 32'h6B3C91E5;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_bit_clock;
  logic        rx_bit_clock;
  logic        rx_data_primary;
  logic        frame_sync_pulse;
  logic        tx_data_primary;
  logic        primary_tx_oe;
  logic        shared_tx_pin;
  logic        shared_tx_pin_oe;
  logic [31:0] rdv;
  logic        er;
  int          fail_count;
  int          n_compared;
  int          p;

  thd_highway_pins thd_highway_pins_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_bit_clock(tx_bit_clock),
    .rx_bit_clock(rx_bit_clock), .rx_data_primary(rx_data_primary),
    .frame_sync_pulse(frame_sync_pulse), .tx_data_primary(tx_data_primary),
    .primary_tx_oe(primary_tx_oe), .shared_tx_pin(shared_tx_pin),
    .shared_tx_pin_oe(shared_tx_pin_oe));

  thd_highway_model #(.NB(32)) thd_highway_model_i (.tx_bit_clock(tx_bit_clock),
    .rx_bit_clock(rx_bit_clock), .rx_data_primary(rx_data_primary),
    .frame_sync_pulse(frame_sync_pulse), .tx_data_primary(tx_data_primary),
    .primary_tx_oe(primary_tx_oe), .shared_tx_pin(shared_tx_pin),
    .shared_tx_pin_oe(shared_tx_pin_oe));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, report and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic wr_en, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      results();
    end
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp, input logic [7:0] m);
    apb(1'b0, idx, 8'h00);
    chk(rdv & {24'h0, m}, {24'h0, exp & m});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit frame: slot, offset, config, clock invert, strobe, enables
  task automatic tx_case(input logic [5:0] s, input logic [2:0] o, input logic [7:0] cfg,
                         input logic ci, input logic st, input logic pe, input logic se);
    int w;
    logic [3:0] l;
    logic b;
    logic inw;
    wr(thd_pkg::IDX_RXCTL, {st, 7'h00});
    wr(thd_pkg::IDX_TXSLOT, {pe, se, s});
    wr(thd_pkg::IDX_OFFS, {o, ci, 4'h1});
    wr(thd_pkg::IDX_TXCFG, cfg);
    thd_highway_model_i.run_frame(PAT, 1'b0);
    for (int q = 0; q < 32; q++) begin
      w = q - (s * 8 + o);
      inw = (w >= 0 && w < 8);
      l = ci ? thd_highway_model_i.lane_r[q] : thd_highway_model_i.lane_f[q];
      b = 1'b0;
      if (inw) b = (cfg[6] ? TXD[7-w] : TXD[w]) ^ cfg[7];
      chk(l[1], pe & inw);
      if (pe & inw) chk(l[0], b);
      chk(l[3], st | (se & inw));
      if (st) chk(l[2], !inw);
      else if (se & inw) chk(l[2], b);
    end
    $display("test tx slot %0d offset %0d done", s, o);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Receive frame: slot, offset, edge, invert, order, pin function, input select
  task automatic rx_case(input logic [5:0] s, input logic [2:0] o, input logic ed,
                         input logic inv, input logic ord, input logic f21, input logic sel);
    logic [7:0] e;
    logic r;
    int w0;
    w0 = s * 8 + o;
    for (int j = 0; j < 8; j++) begin
      r = ((f21 & sel) ? ~PAT[w0+j] : PAT[w0+j]) ^ inv;
      if (ord) e[7-j] = r;
      else e[j] = r;
    end
    wr(thd_pkg::IDX_RXCTL, {1'b0, f21, 6'h00});
    wr(thd_pkg::IDX_RXSLOT, {sel, 1'b0, s});
    wr(thd_pkg::IDX_OFFS, {4'h0, o, ed});
    wr(thd_pkg::IDX_RXCFG, {inv, ord, 6'h00});
    wr(thd_pkg::IDX_STAT, 8'h03);
    thd_highway_model_i.run_frame(PAT, f21);
    rdchk(thd_pkg::IDX_RXDAT, e, 8'hFF);
    rdchk(thd_pkg::IDX_STAT, 8'h03, 8'hFF);
    $display("test rx slot %0d offset %0d done", s, o);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    fail_count = 0;
    n_compared = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    chk(primary_tx_oe, 1'b0);
    chk(shared_tx_pin_oe, 1'b0);
    presetn <= 1'b1;
    rdchk(thd_pkg::IDX_OFFS, 8'h01, 8'hFF);
    rdchk(thd_pkg::IDX_CFG, 8'h00, 8'hFF);
    apb(1'b0, 4'h1, 8'h00);
    chk(er, 1'b1);
    chk(rdv, 32'h0);
    $display("test reset done");
    wr(thd_pkg::IDX_TXSLOT, 8'hC0);
    wr(thd_pkg::IDX_TXDAT, TXD);
    thd_highway_model_i.run_frame(PAT, 1'b0);
    for (p = 0; p < 32; p++) chk(thd_highway_model_i.lane_f[p][1], 1'b0);
    $display("test highway off done");
    wr(thd_pkg::IDX_CFG, 8'h80);
    tx_case(6'd1, 3'd0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
    tx_case(6'd1, 3'd3, 8'h80, 1'b1, 1'b0, 1'b1, 1'b0);
    tx_case(6'd2, 3'd5, 8'h40, 1'b0, 1'b1, 1'b1, 1'b1);
    tx_case(6'd0, 3'd7, 8'hC0, 1'b1, 1'b0, 1'b0, 1'b1);
    rx_case(6'd0, 3'd1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    rx_case(6'd2, 3'd4, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    rx_case(6'd1, 3'd2, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    rx_case(6'd3, 3'd0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    results();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    results();
  end
endmodule
